// ### inc/pps_pkg.sv
// Package for the power protection supervisor: register map, fields, resets, timing.
// Assumes a 125 MHz mclk and a 32-bit Avalon-MM slave with word addressing by byte.
package pps_pkg;
   // Register byte offsets
   localparam logic [5:0] OFS_CTRL = 6'h00;
   localparam logic [5:0] OFS_STATUS = 6'h04;
   localparam logic [5:0] OFS_OVP_CODE = 6'h08;
   localparam logic [5:0] OFS_UVP_CODE = 6'h0c;
   localparam logic [5:0] OFS_DEB_SEL = 6'h10;
   localparam logic [5:0] OFS_SKIP_THR = 6'h14;
   localparam logic [5:0] OFS_CC_CODE = 6'h18;
   localparam logic [5:0] OFS_CV_TARGET = 6'h1c;
   localparam logic [5:0] OFS_CABLE_RES = 6'h20;
   localparam logic [5:0] OFS_CURRENT = 6'h24;
   localparam logic [5:0] OFS_CDC_OFFSET = 6'h28;
   localparam logic [5:0] OFS_FAULT_CLR = 6'h2c;
   // Control register fields
   localparam int CTRL_CONV_EN = 0;
   localparam int CTRL_DEM_EN = 1;
   localparam int CTRL_CDC_EN = 2;
   localparam int CTRL_BLD_DOWN = 3;
   localparam int CTRL_BLD_HRST = 4;
   localparam int CTRL_BLD_DETACH = 5;
   // Status / clear fields
   localparam int ST_OVP = 0;
   localparam int ST_UVP = 1;
   localparam int ST_CPU_EN = 2;
   localparam int ST_CONV_EN = 3;
   localparam int ST_SKIP = 4;
   // Reset values
   localparam logic [7:0] OVP_CODE_RST = 8'hd2;
   localparam logic [7:0] UVP_CODE_RST = 8'h00;
   localparam logic [3:0] SKIP_THR_RST = 4'h4;
   localparam logic [9:0] CC_CODE_RST = 10'h140;
   localparam logic [11:0] CV_TARGET_RST = 12'h1f8;
   localparam logic [7:0] CABLE_RES_RST = 8'h00;
   // Debounce times in microseconds, one per select value
   localparam int DEB_US_0 = 8;
   localparam int DEB_US_1 = 16;
   localparam int DEB_US_2 = 32;
   localparam int DEB_US_3 = 64;
   localparam int CLK_MHZ = 125;
   localparam int DEB_W = 14;
   localparam logic [DEB_W-1:0] DEB_CYC_0 = DEB_W'(DEB_US_0 * CLK_MHZ);
   localparam logic [DEB_W-1:0] DEB_CYC_1 = DEB_W'(DEB_US_1 * CLK_MHZ);
   localparam logic [DEB_W-1:0] DEB_CYC_2 = DEB_W'(DEB_US_2 * CLK_MHZ);
   localparam logic [DEB_W-1:0] DEB_CYC_3 = DEB_W'(DEB_US_3 * CLK_MHZ);
   // Cable-drop ramp: one target code step every so many microseconds
   localparam int CDC_STEP_US = 1;
   localparam logic [7:0] CDC_STEP_CYC = 8'(CDC_STEP_US * CLK_MHZ);
   // Protection debounce states
   typedef enum logic [1:0] {PPS_IDLE = 2'b00, PPS_COUNT = 2'b01, PPS_TRIP = 2'b11} pps_deb_t;
endpackage

// ### logic/pps_top.sv
// Supervisor logic for a buck-boost power stage: lockout, skip/diode decisions,
// OVP/UVP debounce, regulation codes, cable-drop ramp and bleeder control.
// Assumes analog comparator and monitor outputs arrive asynchronously on pins.
// What this block does
// - Processor enabled once main and core supplies good
// - Converter locked out while any lockout active
// - Skip pulses when compensation below threshold
// - Programmable skip threshold sets minimum peak
// - Low-side gate off on zero-current detect
// - Second high gate off on second detect
// - Debounced bus overvoltage faults, stops converter
// - Eight-bit overvoltage code, 100mV steps from 3.3V
// - Selectable overvoltage debounce length
// - Debounced output undervoltage faults, stops converter
// - Eight-bit undervoltage code, 100mV steps from 3V
// - Selectable undervoltage debounce length
// - Trip codes rewritable while running
// - Ten-bit current code, 0.0625mV per step
// - Voltage target moves in 9.93mV steps
// - Bleeders on for downshift, hard reset, detach
// - Cable offset ramps toward current times resistance
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module pps_top (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Avalon-MM slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Supply monitors, active high while in lockout
   input wire logic main_lockout,
   input wire logic core_supply_lockout,
   input wire logic gate_driver_supply_lockout,
   // Analog comparators
   input wire logic compensation_below_skip,
   input wire logic zero_current_detect_low,
   input wire logic zero_current_detect_high,
   input wire logic bus_ovp_cmp,
   input wire logic out_uvp_cmp,
   // Gate requests from the modulator
   input wire logic low_side_gate_req,
   input wire logic second_high_gate_req,
   // Measured output current code from the amplifier's converter
   input wire logic [9:0] output_current_amplifier,
   // Outputs to the power stage and processor
   output logic cpu_enable,
   output logic converter_enable,
   output logic pulse_skip_mode,
   output logic low_side_gate_out,
   output logic second_high_gate_out,
   output logic bleeder_node,
   output logic [7:0] ovp_code,
   output logic [7:0] uvp_code,
   output logic [3:0] skip_threshold,
   output logic [9:0] cc_code,
   output logic [11:0] voltage_regulation_target
);
   logic rst_s1_r, rst_n;
   // Reset release through two flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // Two-flop synchronisers; lockouts reset active, the rest idle
   localparam int NS = 9;
   logic [NS-1:0] pin_raw, pin_s1_r, pin_s_r;
   assign pin_raw = {main_lockout, core_supply_lockout, gate_driver_supply_lockout,
                     compensation_below_skip, zero_current_detect_low,
                     zero_current_detect_high, bus_ovp_cmp, out_uvp_cmp,
                     low_side_gate_req};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 9'h1c0;
         pin_s_r <= 9'h1c0;
      end else begin
         pin_s1_r <= pin_raw;
         pin_s_r <= pin_s1_r;
      end
   end
   logic main_lo, core_lo, gd_lo, comp_low, zcd_lo, zcd_hi, ovp_s, uvp_s, ls_req;
   assign {main_lo, core_lo, gd_lo, comp_low, zcd_lo, zcd_hi, ovp_s, uvp_s, ls_req} = pin_s_r;
   logic hs_s1_r, hs_req;
   // High gate request synchronised separately (reset low)
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         hs_s1_r <= 1'b0;
         hs_req <= 1'b0;
      end else begin
         hs_s1_r <= second_high_gate_req;
         hs_req <= hs_s1_r;
      end
   end

   // Software registers
   logic [5:0] ctrl_r;
   logic [7:0] ovp_code_r, uvp_code_r;
   logic [3:0] deb_sel_r, skip_thr_r;
   logic [9:0] cc_code_r;
   logic [11:0] cv_target_r;
   logic [7:0] cable_res_r;
   logic [1:0] fault_r, fault_clr;
   logic wr_ok;
   assign wr_ok = avs_write && !avs_waitrequest;
   // Register writes; codes may change at any time while running
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= 6'h00;
         ovp_code_r <= pps_pkg::OVP_CODE_RST;
         uvp_code_r <= pps_pkg::UVP_CODE_RST;
         deb_sel_r <= 4'h0;
         skip_thr_r <= pps_pkg::SKIP_THR_RST;
         cc_code_r <= pps_pkg::CC_CODE_RST;
         cv_target_r <= pps_pkg::CV_TARGET_RST;
         cable_res_r <= pps_pkg::CABLE_RES_RST;
      end else if (wr_ok && avs_byteenable[0]) begin
         case (avs_address)
            pps_pkg::OFS_CTRL: ctrl_r <= avs_writedata[5:0];
            pps_pkg::OFS_OVP_CODE: ovp_code_r <= avs_writedata[7:0];
            pps_pkg::OFS_UVP_CODE: uvp_code_r <= avs_writedata[7:0];
            pps_pkg::OFS_DEB_SEL: deb_sel_r <= avs_writedata[3:0];
            pps_pkg::OFS_SKIP_THR: skip_thr_r <= avs_writedata[3:0];
            pps_pkg::OFS_CC_CODE: begin
               if (avs_byteenable[1]) begin
                  cc_code_r <= avs_writedata[9:0];
               end
            end
            pps_pkg::OFS_CV_TARGET: begin
               if (avs_byteenable[1]) begin
                  cv_target_r <= avs_writedata[11:0];
               end
            end
            pps_pkg::OFS_CABLE_RES: cable_res_r <= avs_writedata[7:0];
            default: ;
         endcase
      end
   end
   assign fault_clr = (wr_ok && avs_byteenable[0] && avs_address == pps_pkg::OFS_FAULT_CLR)
                      ? avs_writedata[1:0] : 2'b00;

   // Lockout gating
   logic cpu_en_r, conv_en_r, skip_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_en_r <= 1'b0;
         conv_en_r <= 1'b0;
      end else begin
         cpu_en_r <= !main_lo && !core_lo;
         conv_en_r <= !main_lo && !core_lo && !gd_lo && (fault_r == 2'b00)
                      && ctrl_r[pps_pkg::CTRL_CONV_EN];
      end
   end
   assign cpu_enable = cpu_en_r;
   assign converter_enable = conv_en_r;

   // Skip decision from compensation comparator
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         skip_r <= 1'b0;
      end else begin
         skip_r <= comp_low && conv_en_r;
      end
   end
   assign pulse_skip_mode = skip_r;
   assign skip_threshold = skip_thr_r;

   // Gate outputs: cut on the edge after the synchronised detector reports zero current, when CTRL_DEM_EN is set
   logic ls_r, hs_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ls_r <= 1'b0;
         hs_r <= 1'b0;
      end else begin
         ls_r <= conv_en_r && ls_req
                 && !(ctrl_r[pps_pkg::CTRL_DEM_EN] && zcd_lo);
         hs_r <= conv_en_r && hs_req
                 && !(ctrl_r[pps_pkg::CTRL_DEM_EN] && zcd_hi);
      end
   end
   assign low_side_gate_out = ls_r;
   assign second_high_gate_out = hs_r;

   // Debounce per protection; a glitch returns to idle and clears the count
   logic [1:0] cmp_in;
   assign cmp_in = {uvp_s, ovp_s};
   for (genvar g = 0; g < 2; g++) begin : g_prot
      pps_pkg::pps_deb_t st_r;
      logic [pps_pkg::DEB_W-1:0] cnt_r, deb_len;
      logic [1:0] sel;
      assign sel = deb_sel_r[2*g +: 2];
      always_comb begin
         case (sel)
            2'd0: deb_len = pps_pkg::DEB_CYC_0;
            2'd1: deb_len = pps_pkg::DEB_CYC_1;
            2'd2: deb_len = pps_pkg::DEB_CYC_2;
            default: deb_len = pps_pkg::DEB_CYC_3;
         endcase
      end
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            st_r <= pps_pkg::PPS_IDLE;
            cnt_r <= '0;
         end else begin
            case (st_r)
               pps_pkg::PPS_IDLE: begin
                  cnt_r <= '0;
                  if (cmp_in[g]) begin
                     st_r <= pps_pkg::PPS_COUNT;
                  end
               end
               pps_pkg::PPS_COUNT: begin
                  if (!cmp_in[g]) begin
                     st_r <= pps_pkg::PPS_IDLE;
                     cnt_r <= '0;
                  end else if (cnt_r >= deb_len - 1'b1) begin
                     st_r <= pps_pkg::PPS_TRIP;
                  end else begin
                     cnt_r <= cnt_r + 1'b1;
                  end
               end
               pps_pkg::PPS_TRIP: begin
                  st_r <= pps_pkg::PPS_IDLE;
                  cnt_r <= '0;
               end
               default: st_r <= pps_pkg::PPS_IDLE;
            endcase
         end
      end
      // Latched fault; a new trip wins over a clear in the same cycle
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            fault_r[g] <= 1'b0;
         end else if (st_r == pps_pkg::PPS_TRIP) begin
            fault_r[g] <= 1'b1;
         end else if (fault_clr[g]) begin
            fault_r[g] <= 1'b0;
         end
      end
   end

   // Cable-drop compensation: offset target ramps one code per step time
   logic [17:0] cdc_goal;
   logic [11:0] cdc_off_r;
   logic [7:0] cdc_tick_r;
   logic [12:0] vreg_sum;
   logic [11:0] vreg_r;
   assign cdc_goal = ctrl_r[pps_pkg::CTRL_CDC_EN]
                     ? 18'(output_current_amplifier * cable_res_r) : 18'h00000;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cdc_tick_r <= 8'h00;
         cdc_off_r <= 12'h000;
      end else if (cdc_tick_r >= pps_pkg::CDC_STEP_CYC - 8'h01) begin
         cdc_tick_r <= 8'h00;
         if ({6'h00, cdc_off_r} < (cdc_goal >> 6)) begin
            cdc_off_r <= cdc_off_r + 12'h001;
         end else if ({6'h00, cdc_off_r} > (cdc_goal >> 6)) begin
            cdc_off_r <= cdc_off_r - 12'h001;
         end
      end else begin
         cdc_tick_r <= cdc_tick_r + 8'h01;
      end
   end
   assign vreg_sum = {1'b0, cv_target_r} + {1'b0, cdc_off_r};
   // Saturating regulation target
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vreg_r <= pps_pkg::CV_TARGET_RST;
      end else begin
         vreg_r <= vreg_sum[12] ? 12'hfff : vreg_sum[11:0];
      end
   end
   assign voltage_regulation_target = vreg_r;

   // Codes to the analog trims, bleeder drive
   logic bld_r;
   logic [7:0] ovp_o_r, uvp_o_r;
   logic [9:0] cc_o_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bld_r <= 1'b0;
         ovp_o_r <= pps_pkg::OVP_CODE_RST;
         uvp_o_r <= pps_pkg::UVP_CODE_RST;
         cc_o_r <= pps_pkg::CC_CODE_RST;
      end else begin
         bld_r <= |ctrl_r[pps_pkg::CTRL_BLD_DETACH:pps_pkg::CTRL_BLD_DOWN];
         ovp_o_r <= ovp_code_r;
         uvp_o_r <= uvp_code_r;
         cc_o_r <= cc_code_r;
      end
   end
   assign bleeder_node = bld_r;
   assign ovp_code = ovp_o_r;
   assign uvp_code = uvp_o_r;
   assign cc_code = cc_o_r;

   // Bus answer: one wait cycle for reads and writes, readdata registered
   logic wait_r;
   logic [31:0] rd_r, rd_mux;
   always_comb begin
      case (avs_address)
         pps_pkg::OFS_CTRL: rd_mux = {26'h0, ctrl_r};
         pps_pkg::OFS_STATUS: rd_mux = {27'h0, skip_r, conv_en_r, cpu_en_r, fault_r};
         pps_pkg::OFS_OVP_CODE: rd_mux = {24'h0, ovp_code_r};
         pps_pkg::OFS_UVP_CODE: rd_mux = {24'h0, uvp_code_r};
         pps_pkg::OFS_DEB_SEL: rd_mux = {28'h0, deb_sel_r};
         pps_pkg::OFS_SKIP_THR: rd_mux = {28'h0, skip_thr_r};
         pps_pkg::OFS_CC_CODE: rd_mux = {22'h0, cc_code_r};
         pps_pkg::OFS_CV_TARGET: rd_mux = {20'h0, cv_target_r};
         pps_pkg::OFS_CABLE_RES: rd_mux = {24'h0, cable_res_r};
         pps_pkg::OFS_CURRENT: rd_mux = {22'h0, output_current_amplifier};
         pps_pkg::OFS_CDC_OFFSET: rd_mux = {20'h0, cdc_off_r};
         default: rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wait_r <= 1'b1;
         rd_r <= 32'h00000000;
      end else begin
         wait_r <= !((avs_read || avs_write) && wait_r);
         if (avs_read && wait_r) begin
            rd_r <= rd_mux;
         end
      end
   end
   assign avs_waitrequest = wait_r;
   assign avs_readdata = rd_r;

   // Checks
   ovp_trip_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (g_prot[0].st_r == pps_pkg::PPS_TRIP) |=> fault_r[0] ##1 !conv_en_r)
      else $error("overvoltage trip did not latch and stop converter");
   uvp_trip_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (g_prot[1].st_r == pps_pkg::PPS_TRIP) |=> fault_r[1] ##1 !conv_en_r)
      else $error("undervoltage trip did not latch and stop converter");
   glitch_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (g_prot[0].st_r == pps_pkg::PPS_COUNT && !ovp_s) |=> g_prot[0].cnt_r == '0)
      else $error("debounce count not cleared on glitch");
   fault_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (fault_r[0] && !fault_clr[0]) |=> fault_r[0])
      else $error("fault dropped without clear");
   cpu_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (main_lo || core_lo) |=> !cpu_en_r)
      else $error("processor enabled during lockout");
   conv_lock_a: assert property (@(posedge mclk) disable iff (!rst_n)
      gd_lo |=> !conv_en_r)
      else $error("converter enabled during gate supply lockout");
   low_zcd_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (ctrl_r[pps_pkg::CTRL_DEM_EN] && zcd_lo) |=> !ls_r)
      else $error("low-side gate on after zero current");
   high_zcd_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (ctrl_r[pps_pkg::CTRL_DEM_EN] && zcd_hi) |=> !hs_r)
      else $error("second high gate on after zero current");
   skip_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (comp_low && conv_en_r) |=> skip_r)
      else $error("skip mode not entered");
   bleed_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
      ctrl_r[pps_pkg::CTRL_BLD_HRST] |=> bld_r)
      else $error("bleeder off during hard reset");
endmodule // pps_top

// ### verif/pps_far_side.sv
// Far-side model: bus OVP and output UVP comparators, skip comparator,
// zero-current detectors and the modulator's gate requests.
// Assumes the bench sets analog levels in mV and inductor currents in mA.
`timescale 1ns/1ps
module pps_far_side (
   // Codes from the supervisor
   input wire logic [7:0] ovp_code,
   input wire logic [7:0] uvp_code,
   input wire logic [3:0] skip_threshold,
   // Analog state set by the bench
   input var int bus_mv,
   input var int out_mv,
   input var int comp_lvl,
   input var int il_ma,
   input var int il2_ma,
   input wire logic pwm_on,
   // Comparator and modulator outputs
   output logic bus_ovp_cmp,
   output logic out_uvp_cmp,
   output logic compensation_below_skip,
   output logic zero_current_detect_low,
   output logic zero_current_detect_high,
   output logic low_side_gate_req,
   output logic second_high_gate_req
);
   // Trip levels follow the codes at once, with no hysteresis to hide slips
   assign bus_ovp_cmp = bus_mv > 3300 + 100 * int'(ovp_code);
   assign out_uvp_cmp = out_mv < 3000 + 100 * int'(uvp_code);
   assign compensation_below_skip = comp_lvl < int'(skip_threshold);
   // Current at or below zero counts as a zero-current crossing
   assign zero_current_detect_low = il_ma <= 0;
   assign zero_current_detect_high = il2_ma <= 0;
   // Modulator asks for both gates while switching
   assign low_side_gate_req = pwm_on;
   assign second_high_gate_req = pwm_on;
endmodule // pps_far_side

// ### verif/testbench.sv
// Self-checking bench for the supervisor, with a register model in the bench.
// Assumes the far-side model file is compiled ahead of this one.
`timescale 1ns/1ps
module testbench;
   localparam logic [5:0] A_CTRL = pps_pkg::OFS_CTRL;
   localparam logic [5:0] A_ST = pps_pkg::OFS_STATUS;
   localparam logic [5:0] A_OVP = pps_pkg::OFS_OVP_CODE;
   localparam logic [5:0] A_UVP = pps_pkg::OFS_UVP_CODE;
   localparam logic [5:0] A_DEB = pps_pkg::OFS_DEB_SEL;
   localparam logic [5:0] A_SKIP = pps_pkg::OFS_SKIP_THR;
   localparam logic [5:0] A_CV = pps_pkg::OFS_CV_TARGET;
   localparam logic [5:0] A_RES = pps_pkg::OFS_CABLE_RES;
   localparam logic [5:0] A_CDC = pps_pkg::OFS_CDC_OFFSET;
   localparam logic [5:0] A_CLR = pps_pkg::OFS_FAULT_CLR;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic main_lockout = 1'b1;
   logic core_supply_lockout = 1'b1;
   logic gate_driver_supply_lockout = 1'b1;
   logic pwm_on = 1'b0;
   logic [9:0] output_current_amplifier = 10'h000;
   int bus_mv = 12000;
   int out_mv = 5000;
   int comp_lvl = 10;
   int il_ma = 100;
   int il2_ma = 100;
   logic bus_ovp_cmp, out_uvp_cmp, compensation_below_skip;
   logic zero_current_detect_low, zero_current_detect_high;
   logic low_side_gate_req, second_high_gate_req;
   logic cpu_enable, converter_enable, pulse_skip_mode;
   logic low_side_gate_out, second_high_gate_out, bleeder_node;
   logic [7:0] ovp_code, uvp_code;
   logic [3:0] skip_threshold;
   logic [9:0] cc_code;
   logic [11:0] voltage_regulation_target;
   int failures = 0;
   int check_count = 0;
   logic [31:0] lfsr = 32'h1a02;
   logic [31:0] regm [int];
   int adr [6] = '{A_OVP, A_UVP, A_SKIP, pps_pkg::OFS_CC_CODE, A_CV, A_RES};
   logic [31:0] msk [6] = '{32'hff, 32'hff, 32'hf, 32'h3ff, 32'hfff, 32'hff};
   logic [31:0] rst [6] = '{32'hd2, 32'h00, 32'h4, 32'h140, 32'h1f8, 32'h00};

   pps_top dut (.mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .main_lockout, .core_supply_lockout,
      .gate_driver_supply_lockout, .compensation_below_skip, .zero_current_detect_low,
      .zero_current_detect_high, .bus_ovp_cmp, .out_uvp_cmp, .low_side_gate_req,
      .second_high_gate_req, .output_current_amplifier, .cpu_enable, .converter_enable,
      .pulse_skip_mode, .low_side_gate_out, .second_high_gate_out, .bleeder_node,
      .ovp_code, .uvp_code, .skip_threshold, .cc_code, .voltage_regulation_target);
   pps_far_side far (.ovp_code, .uvp_code, .skip_threshold, .bus_mv, .out_mv, .comp_lvl,
      .il_ma, .il2_ma, .pwm_on, .bus_ovp_cmp, .out_uvp_cmp, .compensation_below_skip,
      .zero_current_detect_low, .zero_current_detect_high, .low_side_gate_req,
      .second_high_gate_req);

   // 125 MHz clock
   always #4 mclk = ~mclk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Output selector so one wait loop serves every level
   function automatic logic sig(input int k);
      case (k)
         0: return cpu_enable;
         1: return converter_enable;
         2: return pulse_skip_mode;
         3: return low_side_gate_out;
         4: return second_high_gate_out;
         default: return bleeder_node;
      endcase
   endfunction

   function automatic logic [31:0] port_val(input int i);
      case (i)
         0: return 32'(ovp_code);
         1: return 32'(uvp_code);
         2: return 32'(skip_threshold);
         3: return 32'(cc_code);
         default: return 32'(voltage_regulation_target);
      endcase
   endfunction

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One Avalon transfer; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         check("waitrequest", 32'(avs_waitrequest), 32'h0);
         print_verdict();
      end
   endtask

   task automatic rd(input logic [5:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   // Waits for a level, no sooner than lo and no later than hi cycles
   task automatic await(input string what, input int k, input logic v, input int lo,
         input int hi);
      int n;
      n = 0;
      while (sig(k) !== v && n <= hi) begin
         @(posedge mclk);
         n++;
      end
      if (n > hi) begin
         failures++;
         $display("MISMATCH %s expected %b seen %b", what, v, sig(k));
         print_verdict();
      end
      check(what, 32'(n >= lo), 32'h1);
   endtask

   task automatic hold(input string what, input int k, input logic v, input int cyc);
      int bad;
      bad = 0;
      repeat (cyc) begin
         @(posedge mclk);
         if (sig(k) !== v) begin
            bad++;
         end
      end
      check(what, 32'(bad), 32'h0);
   endtask

   // Glitch, real trip, latch and clear for one protection and debounce select
   task automatic protect(input int uv, input int sel);
      int deb;
      int safe;
      int trip;
      logic [31:0] q;
      logic [5:0] ca;
      deb = sel == 0 ? 1000 : sel == 1 ? 2000 : sel == 2 ? 4000 : 8000;
      ca = uv ? A_UVP : A_OVP;
      safe = uv ? 20 : 88;
      trip = uv ? 21 : 86;
      wr(A_DEB, 32'(sel << (2 * uv)));
      wr(ca, 32'(safe));
      hold("converter on", 1, 1'b1, 40);
      wr(ca, 32'(trip));
      hold("glitch ignored", 1, 1'b1, deb - 30);
      wr(ca, 32'(safe));
      hold("count cleared", 1, 1'b1, 40);
      wr(ca, 32'(trip));
      await("fault trip", 1, 1'b0, deb, deb + 12);
      rd(A_ST, q);
      check("fault status", q, (32'h1 << (pps_pkg::ST_OVP + uv)) | 32'h4);
      wr(ca, 32'(safe));
      hold("fault latched", 1, 1'b0, 60);
      wr(A_CLR, 32'h1 << uv);
      await("fault cleared", 1, 1'b1, 0, 12);
      $display("test protection %0d select %0d done", uv, sel);
   endtask

   // Main sequence
   initial begin
      logic [31:0] q;
      int cur;
      int exp;
      repeat (12) @(posedge mclk);
      check("target in reset", 32'(voltage_regulation_target), 32'h1f8);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 6; i++) begin
         rd(adr[i], q);
         check("reset value", q, rst[i]);
         lfsr = lfsr_next(lfsr);
         regm[adr[i]] = lfsr & msk[i];
         wr(adr[i], lfsr);
         rd(adr[i], q);
         check("readback", q, regm[adr[i]]);
         if (i < 5) begin
            check("code port", port_val(i), regm[adr[i]]);
         end
      end
      avs_byteenable <= 4'he;
      wr(A_OVP, 32'h0);
      avs_byteenable <= 4'hf;
      rd(A_OVP, q);
      check("lane 0 off", q, regm[A_OVP]);
      wr(6'h30, 32'hffffffff);
      rd(6'h30, q);
      check("unmapped", q, 32'h0);
      wr(A_ST, 32'hffffffff);
      rd(A_ST, q);
      check("status", q, 32'(comp_lvl < int'(regm[A_SKIP])) << pps_pkg::ST_SKIP);
      $display("test registers done");
      // Every lockout combination, all three active first
      wr(A_CTRL, 32'h1);
      for (int c = 7; c >= 0; c--) begin
         {main_lockout, core_supply_lockout, gate_driver_supply_lockout} <= 3'(c);
         @(posedge mclk);
         await("cpu_enable", 0, c[2:1] == 2'b00, 0, 8);
         await("converter_enable", 1, c == 0, 0, 8);
      end
      $display("test lockout done");
      comp_lvl <= 8;
      wr(A_SKIP, 32'h6);
      await("skip off", 2, 1'b0, 0, 8);
      comp_lvl <= 5;
      await("skip on", 2, 1'b1, 0, 8);
      wr(A_SKIP, 32'h4);
      await("skip threshold", 2, 1'b0, 0, 8);
      $display("test skip done");
      pwm_on <= 1'b1;
      wr(A_CTRL, 32'h3);
      await("low gate on", 3, 1'b1, 0, 8);
      il_ma <= -5;
      await("low gate cut", 3, 1'b0, 0, 8);
      il2_ma <= -5;
      await("high gate cut", 4, 1'b0, 0, 8);
      wr(A_CTRL, 32'h1);
      await("low gate forced", 3, 1'b1, 0, 8);
      await("high gate forced", 4, 1'b1, 0, 8);
      pwm_on <= 1'b0;
      await("low gate off", 3, 1'b0, 0, 8);
      $display("test diode emulation done");
      protect(0, 0);
      protect(0, 3);
      protect(1, 1);
      protect(1, 2);
      for (int b = pps_pkg::CTRL_BLD_DOWN; b <= pps_pkg::CTRL_BLD_DETACH; b++) begin
         wr(A_CTRL, 32'h1 | (32'h1 << b));
         await("bleeder on", 5, 1'b1, 0, 8);
         wr(A_CTRL, 32'h1);
         await("bleeder off", 5, 1'b0, 0, 8);
      end
      $display("test bleeder done");
      lfsr = lfsr_next(lfsr);
      cur = 32 + int'(lfsr % 64);
      exp = (cur * 8) >> 6;
      output_current_amplifier <= 10'(cur);
      wr(A_CV, 32'h300);
      wr(A_RES, 32'h8);
      wr(A_CTRL, 32'h5);
      repeat (int'(pps_pkg::CDC_STEP_CYC) * exp / 2) @(posedge mclk);
      rd(A_CDC, q);
      check("ramp midway", 32'(q > 0 && q < exp), 32'h1);
      repeat (int'(pps_pkg::CDC_STEP_CYC) * (exp + 2)) @(posedge mclk);
      rd(A_CDC, q);
      check("cable offset", q, 32'(exp));
      check("target", 32'(voltage_regulation_target), 32'h300 + 32'(exp));
      rd(pps_pkg::OFS_CURRENT, q);
      check("current", q, 32'(cur));
      $display("test cable drop done");
      print_verdict();
   end
endmodule // testbench
